// ### rtl/ieb_bank.sv
// top: enable groups 2-4, level banks 0-2, request gating, Avalon-MM slave, event interrupt
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ieb_bank
    import ieb_pkg::*;
(
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset_n,
    // Avalon-MM slave, word addressed
    input  wire logic [2:0]                avsAddress,
    input  wire logic                      avsRead,
    input  wire logic                      avsWrite,
    input  wire logic [31:0]               avsWritedata,
    input  wire logic [3:0]                avsByteenable,
    output logic      [31:0]               avsReaddata,
    output logic                           avsWaitrequest,
    // sources whose enables live here, levels come from elsewhere
    input  wire logic [IEB_GRP_SRC-1:0]    grpFlag,
    input  wire logic [3*IEB_GRP_SRC-1:0]  grpLevel,
    // sources whose levels live here, enables come from elsewhere
    input  wire logic [IEB_LVL_SRC-1:0]    lvlFlag,
    input  wire logic [IEB_LVL_SRC-1:0]    lvlEnable,
    // requests toward the arbiter
    output logic      [IEB_GRP_SRC-1:0]    grpRequest,
    output logic      [IEB_LVL_SRC-1:0]    lvlRequest,
    // register contents for the rest of the controller
    output logic      [15:0]               enableGroup2,
    output logic      [15:0]               enableGroup3,
    output logic      [15:0]               enableGroup4,
    output logic      [15:0]               levelBank0,
    output logic      [15:0]               levelBank1,
    output logic      [15:0]               levelBank2,
    // event interrupt
    output logic                           irqOut
);

    ieb_bus_state_t          busState;
    ieb_bus_state_t          next_busState;
    logic [30:0]             eventStatus;
    logic [30:0]             eventMask;
    logic [30:0]             next_eventStatus;
    logic [IEB_GRP_SRC-1:0]  grpRise;
    logic [IEB_LVL_SRC-1:0]  lvlRise;
    logic [IEB_GRP_SRC-1:0]  grpEnable;
    logic [3*IEB_LVL_SRC-1:0] lvlLevel;
    logic [31:0]             readMux;

    // address decode and write strobes; a write lands at the edge that ends the answer cycle
    wire        busReq     = avsRead | avsWrite;
    wire        writeNow   = avsWrite & ~avsWaitrequest & (busState == IEB_BUS_ANSWER);
    wire [31:0] laneMask   = iebByteMask(avsByteenable);
    wire        selEn2     = (avsAddress == IEB_OFS_EN2[4:2]);
    wire        selEn3     = (avsAddress == IEB_OFS_EN3[4:2]);
    wire        selEn4     = (avsAddress == IEB_OFS_EN4[4:2]);
    wire        selLvl0    = (avsAddress == IEB_OFS_LVL0[4:2]);
    wire        selLvl1    = (avsAddress == IEB_OFS_LVL1[4:2]);
    wire        selLvl2    = (avsAddress == IEB_OFS_LVL2[4:2]);
    wire        selStatus  = (avsAddress == IEB_OFS_STATUS[4:2]);
    wire        selMask    = (avsAddress == IEB_OFS_MASK[4:2]);

    // bus handshake: one cycle of wait, then one answer cycle
    always_comb
    begin
        next_busState = busState;
        case (busState)
            IEB_BUS_IDLE:   if (busReq) next_busState = IEB_BUS_ANSWER;
            IEB_BUS_ANSWER: next_busState = IEB_BUS_IDLE;
            default:        next_busState = IEB_BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busState       <= IEB_BUS_IDLE;
            avsWaitrequest <= 1'b1;
            avsReaddata    <= 32'h0000_0000;
        end
        else
        begin
            busState       <= next_busState;
            avsWaitrequest <= ~(busState == IEB_BUS_IDLE && busReq);
            if (busState == IEB_BUS_IDLE && avsRead)
                avsReaddata <= readMux;
        end
    end

    // read selection; unused bits and unmapped words read zero
    assign readMux = selEn2    ? {16'h0000, enableGroup2 & IEB_EN2_IMPL}
                   : selEn3    ? {16'h0000, enableGroup3 & IEB_EN3_IMPL}
                   : selEn4    ? {16'h0000, enableGroup4 & IEB_EN4_IMPL}
                   : selLvl0   ? {16'h0000, levelBank0 & IEB_LVL_IMPL}
                   : selLvl1   ? {16'h0000, levelBank1 & IEB_LVL_IMPL}
                   : selLvl2   ? {16'h0000, levelBank2 & IEB_LVL_IMPL}
                   : selStatus ? {1'b0, eventStatus}
                   : selMask   ? {1'b0, eventMask}
                   : 32'h0000_0000;

    // enable registers; only documented bits store
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enableGroup2 <= IEB_EN_RESET;
            enableGroup3 <= IEB_EN_RESET;
            enableGroup4 <= IEB_EN_RESET;
        end
        else if (writeNow)
        begin
            if (selEn2)
                enableGroup2 <= iebMerge(enableGroup2, avsWritedata[15:0],
                                         IEB_EN2_IMPL, laneMask[15:0]);
            if (selEn3)
                enableGroup3 <= iebMerge(enableGroup3, avsWritedata[15:0],
                                         IEB_EN3_IMPL, laneMask[15:0]);
            if (selEn4)
                enableGroup4 <= iebMerge(enableGroup4, avsWritedata[15:0],
                                         IEB_EN4_IMPL, laneMask[15:0]);
        end
    end

    // level banks
    ieb_level_reg u_lvl0
    (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .writeEn    (writeNow & selLvl0),
        .writeData  (avsWritedata[15:0]),
        .writeLanes (laneMask[15:0]),
        .value      (levelBank0)
    );

    ieb_level_reg u_lvl1
    (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .writeEn    (writeNow & selLvl1),
        .writeData  (avsWritedata[15:0]),
        .writeLanes (laneMask[15:0]),
        .value      (levelBank1)
    );

    ieb_level_reg u_lvl2
    (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .writeEn    (writeNow & selLvl2),
        .writeData  (avsWritedata[15:0]),
        .writeLanes (laneMask[15:0]),
        .value      (levelBank2)
    );

    // enable bits of the group sources, source index 0 upward
    assign grpEnable = {enableGroup4[7:4], enableGroup4[2:1],
                        enableGroup3[13], enableGroup3[8],
                        enableGroup3[7:0],
                        enableGroup2[2:0]};

    // level of source j is field j%4 of bank j/4; field 3 is the high one
    assign lvlLevel = {levelBank2[14:12], levelBank2[10:8],
                       levelBank2[6:4],   levelBank2[2:0],
                       levelBank1[14:12], levelBank1[10:8],
                       levelBank1[6:4],   levelBank1[2:0],
                       levelBank0[14:12], levelBank0[10:8],
                       levelBank0[6:4],   levelBank0[2:0]};

    // request gating for both source sets
    ieb_req_gate #(.N(IEB_GRP_SRC)) u_grp_gate
    (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .flag    (grpFlag),
        .enable  (grpEnable),
        .level   (grpLevel),
        .request (grpRequest),
        .rise    (grpRise)
    );

    ieb_req_gate #(.N(IEB_LVL_SRC)) u_lvl_gate
    (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .flag    (lvlFlag),
        .enable  (lvlEnable),
        .level   (lvlLevel),
        .request (lvlRequest),
        .rise    (lvlRise)
    );

    // sticky event status, write one to clear; a new event beats the clear
    wire [30:0] statusClear = (writeNow & selStatus) ? (avsWritedata[30:0] & laneMask[30:0])
                                                     : 31'h0000_0000;
    assign next_eventStatus = (eventStatus & ~statusClear) | {lvlRise, grpRise};

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            eventStatus <= IEB_STAT_RESET;
            eventMask   <= IEB_STAT_RESET;
            irqOut      <= 1'b0;
        end
        else
        begin
            eventStatus <= next_eventStatus;
            if (writeNow & selMask)
                eventMask <= (eventMask & ~laneMask[30:0]) | (avsWritedata[30:0] & laneMask[30:0]);
            irqOut      <= |(eventStatus & eventMask);   // level, one cycle behind status
        end
    end

endmodule // ieb_bank

// ### rtl/ieb_level_reg.sv
// one priority register: four 3-bit level fields, gaps read zero
`timescale 1ns/1ps
module ieb_level_reg
    import ieb_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // write port
    input  wire logic        writeEn,
    input  wire logic [15:0] writeData,
    input  wire logic [15:0] writeLanes,
    // stored value
    output logic      [15:0] value
);

    // fields at 14-12, 10-8, 6-4, 2-0 load level four at reset
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            value <= IEB_LVL_RESET;
        else if (writeEn)
            value <= iebMerge(value, writeData, IEB_LVL_IMPL, writeLanes);
    end

endmodule // ieb_level_reg

// ### rtl/ieb_pkg.sv
// package: register map, field layout, reset values and helpers of the enable/level bank
package ieb_pkg;

    // register byte offsets (one aligned 32-bit word each)
    localparam logic [7:0]  IEB_OFS_EN2      = 8'h00;
    localparam logic [7:0]  IEB_OFS_EN3      = 8'h04;
    localparam logic [7:0]  IEB_OFS_EN4      = 8'h08;
    localparam logic [7:0]  IEB_OFS_LVL0     = 8'h0C;
    localparam logic [7:0]  IEB_OFS_LVL1     = 8'h10;
    localparam logic [7:0]  IEB_OFS_LVL2     = 8'h14;
    localparam logic [7:0]  IEB_OFS_STATUS   = 8'h18;
    localparam logic [7:0]  IEB_OFS_MASK     = 8'h1C;

    // implemented bits of each register
    localparam logic [15:0] IEB_EN2_IMPL     = 16'h0007;
    localparam logic [15:0] IEB_EN3_IMPL     = 16'h21FF;
    localparam logic [15:0] IEB_EN4_IMPL     = 16'h00F6;
    localparam logic [15:0] IEB_LVL_IMPL     = 16'h7777;

    // reset values
    localparam logic [15:0] IEB_EN_RESET     = 16'h0000;
    localparam logic [15:0] IEB_LVL_RESET    = 16'h4444;
    localparam logic [30:0] IEB_STAT_RESET   = 31'h0000_0000;

    // level field layout: four 3-bit fields at a pitch of four bits, and the level value that means off
    localparam int          IEB_LVL_W        = 3;
    localparam int          IEB_FLD_PITCH    = 4;
    localparam logic [2:0]  IEB_LVL_OFF      = 3'h0;

    // source counts
    localparam int          IEB_GRP_SRC      = 19;
    localparam int          IEB_LVL_SRC      = 12;
    localparam int          IEB_ALL_SRC      = 31;

    // bus answer states
    typedef enum logic {IEB_BUS_IDLE, IEB_BUS_ANSWER} ieb_bus_state_t;

    // a level field of zero disables the source
    function automatic logic iebLevelActive(input logic [2:0] lvl);
        iebLevelActive = (lvl != IEB_LVL_OFF);
    endfunction

    // byte enables widened to a bit mask
    function automatic logic [31:0] iebByteMask(input logic [3:0] be);
        iebByteMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // merge a write into a register, touching only implemented and enabled bits
    function automatic logic [15:0] iebMerge(input logic [15:0] old, input logic [15:0] wdata,
                                             input logic [15:0] impl, input logic [15:0] lanes);
        iebMerge = (old & ~(impl & lanes)) | (wdata & impl & lanes);
    endfunction

endpackage

// ### rtl/ieb_req_gate.sv
// request gating: flag, enable and nonzero level give a request; rising requests pulse
`timescale 1ns/1ps
module ieb_req_gate
    import ieb_pkg::*;
#(
    parameter int N = 1
)
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // per-source inputs
    input  wire logic [N-1:0]     flag,
    input  wire logic [N-1:0]     enable,
    input  wire logic [3*N-1:0]   level,
    // per-source outputs
    output logic      [N-1:0]     request,
    output logic      [N-1:0]     rise
);

    logic [N-1:0] next_request;

    // a zero level blocks the source whatever its enable holds
    for (genvar i = 0; i < N; i++)
    begin : g_src
        assign next_request[i] = flag[i] & enable[i]
                               & iebLevelActive(level[3*i +: 3]);
    end

    // registered request and its rising edge
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            request <= '0;
            rise    <= '0;
        end
        else
        begin
            request <= next_request;
            rise    <= next_request & ~request;
        end
    end

endmodule // ieb_req_gate

// ### tb/ieb_bank_assertions.sv
// checker: bus timing, request gating and interrupt relations of the bank
`timescale 1ns/1ps
module ieb_bank_checker
    import ieb_pkg::*;
(
    // clock, reset, bus
    input wire logic                     sys_clk,
    input wire logic                     reset_n,
    input wire logic [2:0]               avsAddress,
    input wire logic                     avsRead,
    input wire logic                     avsWrite,
    input wire logic [31:0]              avsReaddata,
    input wire logic                     avsWaitrequest,
    // sources and requests
    input wire logic [IEB_GRP_SRC-1:0]   grpFlag,
    input wire logic [3*IEB_GRP_SRC-1:0] grpLevel,
    input wire logic [IEB_LVL_SRC-1:0]   lvlFlag,
    input wire logic [IEB_LVL_SRC-1:0]   lvlEnable,
    input wire logic [IEB_GRP_SRC-1:0]   grpRequest,
    input wire logic [IEB_LVL_SRC-1:0]   lvlRequest,
    // registers and interrupt
    input wire logic [15:0]              enableGroup2,
    input wire logic [15:0]              enableGroup3,
    input wire logic [15:0]              enableGroup4,
    input wire logic [15:0]              levelBank0,
    input wire logic [15:0]              levelBank1,
    input wire logic [15:0]              levelBank2,
    input wire logic                     irqOut
);
    logic [IEB_GRP_SRC-1:0] grpEn;
    logic [IEB_GRP_SRC-1:0] grpLvOk;
    logic [IEB_LVL_SRC-1:0] lvlOk;
    logic [47:0]            lvlAll;
    // enables and nonzero levels in source order
    assign grpEn  = {enableGroup4[7:4], enableGroup4[2:1], enableGroup3[13],
                     enableGroup3[8:0], enableGroup2[2:0]};
    assign lvlAll = {levelBank2, levelBank1, levelBank0};
    for (genvar i = 0; i < IEB_GRP_SRC; i++)
    begin : gLv
        assign grpLvOk[i] = |grpLevel[3*i +: 3];
    end
    for (genvar j = 0; j < IEB_LVL_SRC; j++)
    begin : lLv
        assign lvlOk[j] = |lvlAll[4*j +: 3];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_wait_one: assert property (!avsWaitrequest |=> avsWaitrequest)
        else $error("waitrequest low longer than one cycle");
    chk_wait_answer: assert property (avsWaitrequest && (avsRead || avsWrite) |=> !avsWaitrequest)
        else $error("bus request not answered next cycle");
    chk_grp_gate: assert property ($past(reset_n) |-> grpRequest == $past(grpFlag & grpEn & grpLvOk))
        else $error("group request differs from flag, enable and level");
    chk_lvl_gate: assert property ($past(reset_n) |-> lvlRequest == $past(lvlFlag & lvlEnable & lvlOk))
        else $error("level request differs from flag, enable and level");
    chk_unused_zero: assert property (((enableGroup2 & 16'hFFF8) | (enableGroup3 & 16'hDE00)
        | (enableGroup4 & 16'hFF09) | ((levelBank0 | levelBank1 | levelBank2) & 16'h8888)) == 16'h0000)
        else $error("unimplemented register bit set");
    chk_read_upper: assert property (!avsWaitrequest && avsRead
        && avsAddress < IEB_OFS_STATUS[4:2] |-> avsReaddata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    chk_reg_write: assert property (!$stable({enableGroup2, enableGroup3, enableGroup4, lvlAll})
        |-> $past(avsWrite && !avsWaitrequest))
        else $error("register changed without a write");
    chk_irq_fall: assert property ($fell(irqOut) |-> $past(avsWrite, 2))
        else $error("interrupt dropped without a write");
    chk_irq_rise: assert property ($rose(irqOut) |-> $past(|{grpRequest, lvlRequest}, 2) || $past(avsWrite, 2))
        else $error("interrupt rose without a cause");
    cov_irq: cover property ($rose(irqOut));
    cov_grp: cover property (|grpRequest);
    cov_lvl: cover property (|lvlRequest);
endmodule // ieb_bank_checker
bind ieb_bank ieb_bank_checker chk_u (.*);

// ### tb/ieb_src_model.sv
// source model: peripheral flags, levels and lower enables feeding the bank
`timescale 1ns/1ps
module ieb_src_model
    import ieb_pkg::*;
(
    // controls from the bench
    input  wire logic                     grpOn,
    input  wire logic                     lvlOn,
    input  wire logic                     lvlEnOn,
    input  wire logic [2:0]               srcLevel,
    // toward the bank
    output logic      [IEB_GRP_SRC-1:0]   grpFlag,
    output logic      [3*IEB_GRP_SRC-1:0] grpLevel,
    output logic      [IEB_LVL_SRC-1:0]   lvlFlag,
    output logic      [IEB_LVL_SRC-1:0]   lvlEnable
);
    // flags are held levels; all group sources share one level
    assign grpFlag   = {IEB_GRP_SRC{grpOn}};
    assign grpLevel  = {IEB_GRP_SRC{srcLevel}};
    assign lvlFlag   = {IEB_LVL_SRC{lvlOn}};
    assign lvlEnable = {IEB_LVL_SRC{lvlEnOn}};
endmodule // ieb_src_model

// ### tb/tb_irq_enable_priority_bank.sv
// testbench: register access, request gating and event interrupt of the bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_irq_enable_priority_bank
    import ieb_pkg::*;
;
    localparam logic [18:0] GRP_EXP = {4'hA, 2'h2, 2'h3, 8'h01, 3'h5};
    logic                     sys_clk, reset_n, avsRead, avsWrite, avsWaitrequest, irqOut;
    logic [2:0]               avsAddress, srcLevel;
    logic [31:0]              avsWritedata, avsReaddata, rdVal;
    logic [3:0]               avsByteenable;
    logic [IEB_GRP_SRC-1:0]   grpFlag, grpRequest;
    logic [3*IEB_GRP_SRC-1:0] grpLevel;
    logic [IEB_LVL_SRC-1:0]   lvlFlag, lvlEnable, lvlRequest;
    logic [15:0]              enableGroup2, enableGroup3, enableGroup4;
    logic [15:0]              levelBank0, levelBank1, levelBank2;
    logic                     grpOn, lvlOn, lvlEnOn;
    int                       error_cnt, total_checks;
    ieb_bank dut_u (.*);
    ieb_src_model src_u (.*);
    // clock
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one transfer, request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       input logic [3:0] be);
        int n;
        n = 0;
        avsAddress <= ofs[4:2];
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= wd;
        avsByteenable <= be;
        @(posedge sys_clk);
        while (avsWaitrequest !== 1'b0)
        begin
            n++;
            if (n > 20)
            begin
                error_cnt++;
                wrap_up();
            end
            @(posedge sys_clk);
        end
        rdVal = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdChk(input logic [7:0] ofs, input logic [31:0] exp, input string nm);
        bus(1'b0, ofs, 32'h0000_0000, 4'hF);
        `CHK(nm, exp, rdVal)
    endtask
    task automatic t_reset();
        logic [15:0] rst [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h4444, 16'h4444, 16'h4444,
                                 16'h0000, 16'h0000};
        for (int i = 0; i < 8; i++)
            rdChk(8'(4*i), {16'h0000, rst[i]}, "reset value");
        `CHK("irq at reset", 1'b0, irqOut)
        $display("reset test done");
    endtask
    task automatic t_access();
        logic [15:0] impl [6] = '{16'h0007, 16'h21FF, 16'h00F6, 16'h7777, 16'h7777, 16'h7777};
        logic [95:0] regsOut;
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, 8'(4*i), 32'hFFFF_FFFF, 4'hF);
            rdChk(8'(4*i), {16'h0000, impl[i]}, "all ones");
        end
        // register contents also leave the bank as ports
        regsOut = {enableGroup2, enableGroup3, enableGroup4, levelBank0, levelBank1, levelBank2};
        `CHK("enable outputs", {impl[0], impl[1], impl[2]}, regsOut[95:48])
        `CHK("level outputs", {impl[3], impl[4], impl[5]}, regsOut[47:0])
        bus(1'b1, IEB_OFS_EN3, 32'h0000_0000, 4'h2);
        rdChk(IEB_OFS_EN3, 32'h0000_00FF, "lane write");
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, 8'(4*i), 32'h0000_0000, 4'hF);
            rdChk(8'(4*i), 32'h0000_0000, "all zero");
        end
        $display("access test done");
    endtask
    task automatic t_levels();
        lvlOn <= 1'b1;
        lvlEnOn <= 1'b1;
        bus(1'b1, IEB_OFS_LVL0, 32'h0000_7010, 4'hF);
        bus(1'b1, IEB_OFS_LVL1, 32'h0000_0107, 4'hF);
        bus(1'b1, IEB_OFS_LVL2, 32'h0000_1070, 4'hF);
        tick(2);
        `CHK("level gating", 12'hA5A, lvlRequest)
        lvlEnOn <= 1'b0;
        tick(2);
        `CHK("level enable off", 12'h000, lvlRequest)
        lvlOn <= 1'b0;
        $display("level test done");
    endtask
    task automatic t_groups();
        grpOn <= 1'b1;
        srcLevel <= 3'h1;
        bus(1'b1, IEB_OFS_EN2, 32'h0000_0005, 4'hF);
        bus(1'b1, IEB_OFS_EN3, 32'h0000_2101, 4'hF);
        bus(1'b1, IEB_OFS_EN4, 32'h0000_00A4, 4'hF);
        tick(2);
        `CHK("group gating", GRP_EXP, grpRequest)
        srcLevel <= 3'h0;
        tick(2);
        `CHK("group level zero", 19'h0_0000, grpRequest)
        srcLevel <= 3'h7;
        tick(2);
        `CHK("group level seven", GRP_EXP, grpRequest)
        $display("group test done");
    endtask
    task automatic t_irq();
        grpOn <= 1'b0;
        bus(1'b1, IEB_OFS_STATUS, 32'h7FFF_FFFF, 4'hF);
        rdChk(IEB_OFS_STATUS, 32'h0000_0000, "status cleared");
        grpOn <= 1'b1;
        tick(3);
        rdChk(IEB_OFS_STATUS, {13'h0000, GRP_EXP}, "status set");
        `CHK("irq masked", 1'b0, irqOut)
        bus(1'b1, IEB_OFS_MASK, 32'h0000_0001, 4'hF);
        tick(1);
        `CHK("irq raised", 1'b1, irqOut)
        bus(1'b1, IEB_OFS_STATUS, 32'h0000_0001, 4'hF);
        tick(1);
        `CHK("irq cleared", 1'b0, irqOut)
        $display("irq test done");
    endtask
    // reset, then the scenarios in order
    initial
    begin
        reset_n = 1'b0;
        {avsRead, avsWrite, avsAddress, avsWritedata, avsByteenable} = '0;
        {grpOn, lvlOn, lvlEnOn, srcLevel} = '0;
        error_cnt = 0;
        total_checks = 0;
        tick(20);
        reset_n <= 1'b1;
        tick(1);
        t_reset();
        t_access();
        t_levels();
        t_groups();
        t_irq();
        wrap_up();
    end
endmodule // tb_irq_enable_priority_bank
